// ==== hw/ep_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none

module ep_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // Fill side
  input  wire logic [W-1:0] i_wr_data,
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  // Drain side
  output logic      [W-1:0] o_rd_data,
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  wire           push = i_wr_valid && o_wr_ready;
  wire           pop  = o_rd_valid && i_rd_ready;

  assign o_wr_ready = (count_q != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_q != '0);
  assign o_rd_data  = mem_q[rd_ptr_q];

  // Storage has no reset; only the pointers and the count need one
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ==== hw/ep_pkg.sv ====
package ep_pkg;

  // ========================================================
  // Link speed in ddr mode
  typedef enum logic [1:0] {
    EP_SPD_10,
    EP_SPD_100,
    EP_SPD_1000
  } ep_speed_t;

  // ========================================================
  // Transmit sequencer
  typedef enum logic {
    EP_TX_IDLE,
    EP_TX_DATA
  } ep_tx_state_t;

endpackage

// ==== hw/ep_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ep_regs.svh"

//Function
// - Reduced mode drives a reference clock output for the external phy.
// - Transmit enable rises with first preamble di-bit, stays high while di-bits flow.
// - Transmit di-bit, bit 1 most significant, changes on the reference clock.
// - Receive di-bits are accepted only while carrier/data-valid samples high.
// - Carrier/data-valid is asynchronous and is synchronised before use.
// - Receive error high in a frame marks that frame as errored.
// - Receive di-bit, bit 1 most significant, sampled on the reference clock.
// - Ddr mode also drives a reference clock output for the phy.
// - Ddr transmit clock follows selected speed: 125, 25 or 2.5 MHz; with the 25 MHz core this gives 12.5, 12.5 and 2.5 MHz.
// - Ddr transmit nibble changes on both rising and falling clock edges.
// - Ddr receive nibble is captured on both rising and falling edges.
// - Transmit control: enable at rise, derived enable/error value at fall.
// - Receive control: valid at rise, derived valid/error at fall, both decoded.
module ep_port #(
  parameter int FIFO_DEPTH = `EP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  // Mode
  input  wire logic             i_mode_ddr,
  input  wire ep_pkg::ep_speed_t i_speed,
  // Transmit stream
  input  wire logic [7:0]       i_tx_data,
  input  wire logic             i_tx_last,
  input  wire logic             i_tx_err,
  input  wire logic             i_tx_valid,
  output logic                  o_tx_ready,
  output logic                  o_tx_underrun,
  // Receive stream
  output logic      [7:0]       o_rx_data,
  output logic                  o_rx_valid,
  output logic                  o_rx_last,
  output logic                  o_rx_err,
  // Reduced pins
  input  wire logic             i_rmii_ref_clk,
  output logic                  o_reduced_phy_clock_out,
  output logic                  o_rmii_tx_en,
  output logic      [1:0]       o_rmii_txd,
  input  wire logic             i_rmii_crs_dv,
  input  wire logic             i_rmii_rx_er,
  input  wire logic [1:0]       i_rmii_rxd,
  // Ddr pins
  output logic                  o_ddr_phy_clock_out,
  output logic                  o_rgmii_txc,
  output logic      [3:0]       o_rgmii_txd,
  output logic                  o_rgmii_tx_ctl,
  input  wire logic             i_rgmii_rxc,
  input  wire logic             i_rgmii_rx_ctl,
  input  wire logic [3:0]       i_rgmii_rxd
);

  import ep_pkg::*;

  // ========================================================
  // Half-period counts
  // The core clock is under twice the fast rates, so those
  // clamp to one cycle per half period: a real part needs a
  // faster core clock for full speed.
  function automatic logic [7:0] half_cnt(input longint hz);
    longint c;
    c = longint'(`EP_CORE_HZ) / (2 * hz);
    half_cnt = (c < 1) ? 8'h01 : 8'(c);
  endfunction

  localparam logic [7:0] HALF_REF  = half_cnt(`EP_RMII_REF_HZ);
  localparam logic [7:0] HALF_1000 = half_cnt(`EP_TXC_HZ_1000);
  localparam logic [7:0] HALF_100  = half_cnt(`EP_TXC_HZ_100);
  localparam logic [7:0] HALF_10   = half_cnt(`EP_TXC_HZ_10);

  // ========================================================
  // Pin synchronisers
  logic [10:0] pins_s;
  logic        ref_s_q;
  logic        rxc_s_q;

  ep_sync #(.W(11)) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_rmii_ref_clk, i_rmii_crs_dv, i_rmii_rx_er, i_rmii_rxd,
                  i_rgmii_rxc, i_rgmii_rx_ctl, i_rgmii_rxd}),
    .o_sync     (pins_s)
  );

  wire       ref_s   = pins_s[10];
  wire       crs_dv  = pins_s[9];
  wire       rx_er   = pins_s[8];
  wire [1:0] rxd2    = pins_s[7:6];
  wire       rxc_s   = pins_s[5];
  wire       rx_ctl  = pins_s[4];
  wire [3:0] rxd4    = pins_s[3:0];
  wire       ref_rise = !i_mode_ddr && ref_s && !ref_s_q;
  wire       rxc_rise = i_mode_ddr && rxc_s && !rxc_s_q;
  wire       rxc_fall = i_mode_ddr && !rxc_s && rxc_s_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_s_q <= 1'b0;
      rxc_s_q <= 1'b0;
    end else begin
      ref_s_q <= ref_s;
      rxc_s_q <= rxc_s;
    end
  end

  // ========================================================
  // Clock dividers
  logic [7:0] ref_cnt_q;
  logic       ref_clk_q;
  logic [7:0] txc_cnt_q;
  wire  [7:0] txc_half = (i_speed == EP_SPD_1000) ? HALF_1000 :
                         (i_speed == EP_SPD_100)  ? HALF_100 : HALF_10;
  wire        ref_tick  = (ref_cnt_q >= HALF_REF - 8'h01);
  wire        half_tick = i_mode_ddr && (txc_cnt_q >= txc_half - 8'h01);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_cnt_q <= 8'h00;
      ref_clk_q <= 1'b0;
      txc_cnt_q <= 8'h00;
    end else begin
      ref_cnt_q <= ref_tick ? 8'h00 : ref_cnt_q + 8'h01;
      ref_clk_q <= ref_tick ? !ref_clk_q : ref_clk_q;
      txc_cnt_q <= (half_tick || !i_mode_ddr) ? 8'h00 : txc_cnt_q + 8'h01;
    end
  end

  assign o_reduced_phy_clock_out = !i_mode_ddr && ref_clk_q;
  assign o_ddr_phy_clock_out     = i_mode_ddr && ref_clk_q;

  // ========================================================
  // Transmit buffer
  logic [9:0] f_data;
  logic       f_valid;
  logic       f_pop;

  ep_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_wr_data  ({i_tx_err, i_tx_last, i_tx_data}),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .o_rd_data  (f_data),
    .o_rd_valid (f_valid),
    .i_rd_ready (f_pop)
  );

  // ========================================================
  // Transmit sequencer
  ep_tx_state_t tx_state_q;
  logic [7:0]   cur_q;
  logic         cur_last_q;
  logic         cur_err_q;
  logic [1:0]   cnt_q;
  logic         txc_q;

  wire tx_step  = i_mode_ddr ? half_tick : ref_rise;
  wire first    = i_mode_ddr ? !txc_q : (cnt_q == 2'h0);
  wire at_start = tx_step && first;
  wire busy     = (tx_state_q == EP_TX_DATA);
  wire frame_end = busy && cur_last_q;
  wire load     = at_start && f_valid && !frame_end;
  wire stop     = at_start && !load;
  wire [1:0] dibit = cur_q[{cnt_q, 1'b0} +: 2];

  assign f_pop = load;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_state_q <= EP_TX_IDLE;
      cur_q      <= 8'h00;
      cur_last_q <= 1'b0;
      cur_err_q  <= 1'b0;
      cnt_q      <= 2'h0;
      txc_q      <= 1'b0;
    end else begin
      if (half_tick) begin
        txc_q <= !txc_q;
      end else if (!i_mode_ddr) begin
        txc_q <= 1'b0;
      end
      if (load) begin
        tx_state_q <= EP_TX_DATA;
        cur_q      <= f_data[7:0];
        cur_last_q <= f_data[8];
        cur_err_q  <= f_data[9];
        cnt_q      <= 2'h1;
      end else if (stop) begin
        tx_state_q <= EP_TX_IDLE;
        cur_last_q <= 1'b0;
        cur_err_q  <= 1'b0;
      end else if (tx_step && !i_mode_ddr && busy) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  // Reduced transmit pins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rmii_tx_en <= 1'b0;
      o_rmii_txd   <= 2'h0;
    end else if (!i_mode_ddr) begin
      if (load) begin
        o_rmii_tx_en <= 1'b1;
        o_rmii_txd   <= f_data[1:0];
      end else if (stop) begin
        o_rmii_tx_en <= 1'b0;
        o_rmii_txd   <= 2'h0;
      end else if (tx_step && busy) begin
        o_rmii_txd   <= dibit;
      end
    end else begin
      o_rmii_tx_en <= 1'b0;
      o_rmii_txd   <= 2'h0;
    end
  end

  // Ddr transmit pins: low nibble at rise, high nibble at fall
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rgmii_txc    <= 1'b0;
      o_rgmii_txd    <= 4'h0;
      o_rgmii_tx_ctl <= 1'b0;
    end else if (half_tick) begin
      o_rgmii_txc <= !txc_q;
      if (load) begin
        o_rgmii_txd    <= f_data[3:0];
        o_rgmii_tx_ctl <= 1'b1;
      end else if (stop) begin
        o_rgmii_txd    <= 4'h0;
        o_rgmii_tx_ctl <= 1'b0;
      end else begin
        o_rgmii_txd    <= cur_q[7:4];
        o_rgmii_tx_ctl <= busy ^ cur_err_q;
      end
    end else if (!i_mode_ddr) begin
      o_rgmii_txc    <= 1'b0;
      o_rgmii_txd    <= 4'h0;
      o_rgmii_tx_ctl <= 1'b0;
    end
  end

  // Frame cut short because the buffer ran dry
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_underrun <= 1'b0;
    end else begin
      o_tx_underrun <= stop && busy && !cur_last_q;
    end
  end

  // ========================================================
  // Receive assembly
  logic [7:0] sh_q;
  logic [1:0] rcnt_q;
  logic       in_frame_q;
  logic       rx_err_q;
  logic       dv_q;
  logic [7:0] hold_q;
  logic       hold_v_q;

  wire rmii_take  = ref_rise && crs_dv;
  wire rmii_end   = ref_rise && !crs_dv && in_frame_q;
  wire ddr_end    = rxc_rise && !rx_ctl && in_frame_q;
  wire ddr_take   = rxc_fall && dv_q;
  wire byte_done  = (rmii_take && rcnt_q == `EP_DIBIT_LAST) || ddr_take;
  wire frame_done = rmii_end || ddr_end;
  wire [7:0] new_byte = ddr_take ? {rxd4, sh_q[3:0]} : {rxd2, sh_q[7:2]};
  wire err_hit = (rmii_take && rx_er) ||
                 (ddr_take && (rx_ctl ^ dv_q));

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_q       <= 8'h00;
      rcnt_q     <= 2'h0;
      in_frame_q <= 1'b0;
      rx_err_q   <= 1'b0;
      dv_q       <= 1'b0;
      hold_q     <= 8'h00;
      hold_v_q   <= 1'b0;
    end else begin
      if (rmii_take) begin
        sh_q   <= new_byte;
        rcnt_q <= rcnt_q + 2'h1;
      end
      if (rxc_rise) begin
        dv_q <= rx_ctl;
        if (rx_ctl) begin
          sh_q[3:0] <= rxd4;
        end
      end
      if (rmii_take || ddr_take) begin
        in_frame_q <= 1'b1;
      end
      // One byte held back so the last one can carry the end mark
      if (frame_done) begin
        in_frame_q <= 1'b0;
        rcnt_q     <= 2'h0;
        rx_err_q   <= 1'b0;
        hold_v_q   <= 1'b0;
      end else begin
        if (err_hit) begin
          rx_err_q <= 1'b1;
        end
        if (byte_done) begin
          hold_q   <= new_byte;
          hold_v_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_data  <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_last  <= 1'b0;
      o_rx_err   <= 1'b0;
    end else begin
      o_rx_valid <= hold_v_q && (byte_done || frame_done);
      o_rx_data  <= hold_q;
      o_rx_last  <= frame_done;
      o_rx_err   <= frame_done && (rx_err_q || err_hit);
    end
  end

endmodule

`default_nettype wire

// ==== hw/ep_regs.svh ====
`ifndef EP_REGS_SVH
`define EP_REGS_SVH

// ==========================================================
// Clock rates
`define EP_CORE_HZ         25000000
`define EP_RMII_REF_HZ     50000000
`define EP_TXC_HZ_1000     125000000
`define EP_TXC_HZ_100      25000000
`define EP_TXC_HZ_10       2500000

// ==========================================================
// Framing and buffering
`define EP_FIFO_DEPTH      8
`define EP_BYTE_W          8
`define EP_DIBIT_LAST      2'h3
`define EP_SYNC_STAGES     2

`endif

// ==== hw/ep_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module ep_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== sim/ep_phy_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ep_phy_model (
  // Clock
  input  wire logic       i_core_clk,
  // Reduced pins
  output logic            o_ref_clk,
  input  wire logic       i_tx_en,
  input  wire logic [1:0] i_txd,
  output logic            o_crs_dv,
  output logic            o_rx_er,
  output logic [1:0]      o_rxd,
  // Ddr pins
  input  wire logic       i_txc,
  input  wire logic [3:0] i_txd4,
  input  wire logic       i_tx_ctl,
  output logic            o_rxc,
  output logic            o_rx_ctl,
  output logic [3:0]      o_rxd4
);
  logic [8:0] tx_q[$];
  logic [7:0] sh;
  logic [3:0] lo;
  logic       txc_p;
  logic       en;
  int         n;

  initial begin
    o_ref_clk = 0;
    {o_crs_dv, o_rx_er, o_rxd, o_rxc, o_rx_ctl, o_rxd4} = '0;
    {sh, lo, txc_p, en} = '0;
    n = 0;
  end

  // ==========================================================
  // Reference clock, 4 core cycles a half so no edge is missed
  always #160 o_ref_clk = ~o_ref_clk;

  // ==========================================================
  // Transmit capture, low dibit or nibble first
  always @(posedge o_ref_clk) begin
    if (i_tx_en === 1) begin
      sh = {i_txd, sh[7:2]};
      n = n + 1;
      if (n == 4) begin
        tx_q.push_back({1'b0, sh});
        n = 0;
      end
    end else begin
      n = 0;
    end
  end

  always @(negedge i_core_clk) begin
    if (i_txc === 1 && !txc_p) begin
      en = i_tx_ctl;
      lo = i_txd4;
    end
    if (i_txc === 0 && txc_p && en)
      tx_q.push_back({i_tx_ctl ^ en, i_txd4, lo});
    txc_p = i_txc;
  end

  // ==========================================================
  // Receive frames; idle lines show the inverse, never a held value
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge i_core_clk);
  endtask

  task automatic rmii_rx(input logic [7:0] b[3], input int e);
    for (int i = 0; i < 12; i++) begin
      @(negedge o_ref_clk);
      o_crs_dv = 1;
      o_rx_er = (i / 4 == e);
      o_rxd = b[i / 4][2 * (i % 4) +: 2];
    end
    @(negedge o_ref_clk);
    o_crs_dv = 0;
    o_rx_er = 0;
    o_rxd = ~o_rxd;
  endtask

  // Receive clock stands still between frames
  task automatic ddr_rx(input logic [7:0] b[3], input int e);
    for (int i = 0; i < 3; i++) begin
      o_rxd4 = b[i][3:0];
      o_rx_ctl = 1;
      wait_cyc(2);
      o_rxc = 1;
      wait_cyc(2);
      o_rxd4 = b[i][7:4];
      o_rx_ctl = (i != e);
      wait_cyc(2);
      o_rxc = 0;
      wait_cyc(2);
    end
    o_rx_ctl = 0;
    o_rxd4 = ~o_rxd4;
    wait_cyc(2);
    o_rxc = 1;
    wait_cyc(4);
    o_rxc = 0;
  endtask
endmodule

`default_nettype wire

// ==== sim/ep_port_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module ep_port_properties (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  // Watched ports
  input  wire logic              i_mode_ddr,
  input  wire ep_pkg::ep_speed_t i_speed,
  input  wire logic              o_rx_valid,
  input  wire logic              o_reduced_phy_clock_out,
  input  wire logic              o_rmii_tx_en,
  input  wire logic [1:0]        o_rmii_txd,
  input  wire logic              o_ddr_phy_clock_out,
  input  wire logic              o_rgmii_txc,
  input  wire logic [3:0]        o_rgmii_txd,
  input  wire logic              o_rgmii_tx_ctl
);
  import ep_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================
  // Sequences
  // Reference period is at least 6 cycles, so a dibit stands 5 more
  sequence s_dibit_hold;
    $stable(o_rmii_txd) [*5];
  endsequence
  sequence s_slow_half;
    $stable(o_rgmii_txc) [*4];
  endsequence

  // ==========================================================
  // Properties
  ref_out_run_a: assert property (
    !i_mode_ddr |-> ##[1:2] $changed(o_reduced_phy_clock_out))
    else $error("reduced clock output stalled");
  ddr_ref_run_a: assert property (
    i_mode_ddr |-> ##[1:2] $changed(o_ddr_phy_clock_out))
    else $error("ddr clock output stalled");
  ddr_pins_quiet_a: assert property (
    !i_mode_ddr [*3] |-> !o_rgmii_txc && !o_rgmii_tx_ctl
                         && o_rgmii_txd == 4'h0)
    else $error("ddr pins active in reduced mode");
  rmii_pins_quiet_a: assert property (
    i_mode_ddr [*3] |-> !o_rmii_tx_en && o_rmii_txd == 2'h0)
    else $error("reduced pins active in ddr mode");
  tx_en_hold_a: assert property (
    $rose(o_rmii_tx_en) |-> o_rmii_tx_en [*8])
    else $error("transmit enable dropped inside a byte");
  dibit_hold_a: assert property (
    $changed(o_rmii_txd) |=> s_dibit_hold)
    else $error("transmit dibit changed between reference edges");
  rx_valid_pulse_a: assert property (
    o_rx_valid |=> !o_rx_valid [*3])
    else $error("receive valid too long or too dense");
  slow_txc_half_a: assert property (
    $changed(o_rgmii_txc) && i_mode_ddr && i_speed == EP_SPD_10
      |=> s_slow_half)
    else $error("slow transmit clock half period too short");
endmodule

bind ep_port ep_port_properties i_ep_port_properties (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_mode_ddr(i_mode_ddr), .i_speed(i_speed), .o_rx_valid(o_rx_valid),
  .o_reduced_phy_clock_out(o_reduced_phy_clock_out),
  .o_rmii_tx_en(o_rmii_tx_en), .o_rmii_txd(o_rmii_txd),
  .o_ddr_phy_clock_out(o_ddr_phy_clock_out), .o_rgmii_txc(o_rgmii_txc),
  .o_rgmii_txd(o_rgmii_txd), .o_rgmii_tx_ctl(o_rgmii_tx_ctl)
);

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ep_pkg::*;

  // ==========================================================
  // Signals
  logic       clk = 0;
  logic       rst_n = 0;
  logic       mode_ddr = 0;
  ep_speed_t  speed = EP_SPD_10;
  logic [7:0] tx_data = 0;
  logic       tx_last = 0;
  logic       tx_err = 0;
  logic       tx_valid = 0;
  logic       tx_ready, underrun, rx_valid, rx_last, rx_err, tx_en;
  logic       ref_clk, ref_out, ddr_out, crs_dv, rx_er;
  logic       txc, tx_ctl, rxc, rx_ctl;
  logic [7:0] rx_data;
  logic [1:0] txd, rxd;
  logic [3:0] txd4, rxd4;
  logic [9:0] rx_q[$];
  int         n_fail = 0;
  int         checks_done = 0;
  int         refused, underruns, cyc;

  always #20 clk = ~clk;

  ep_port i_ep_port (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_mode_ddr(mode_ddr),
    .i_speed(speed), .i_tx_data(tx_data), .i_tx_last(tx_last),
    .i_tx_err(tx_err), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_tx_underrun(underrun), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_rx_last(rx_last), .o_rx_err(rx_err), .i_rmii_ref_clk(ref_clk),
    .o_reduced_phy_clock_out(ref_out), .o_rmii_tx_en(tx_en),
    .o_rmii_txd(txd), .i_rmii_crs_dv(crs_dv), .i_rmii_rx_er(rx_er),
    .i_rmii_rxd(rxd), .o_ddr_phy_clock_out(ddr_out), .o_rgmii_txc(txc),
    .o_rgmii_txd(txd4), .o_rgmii_tx_ctl(tx_ctl), .i_rgmii_rxc(rxc),
    .i_rgmii_rx_ctl(rx_ctl), .i_rgmii_rxd(rxd4)
  );

  ep_phy_model i_ep_phy_model (
    .i_core_clk(clk), .o_ref_clk(ref_clk), .i_tx_en(tx_en), .i_txd(txd),
    .o_crs_dv(crs_dv), .o_rx_er(rx_er), .o_rxd(rxd), .i_txc(txc),
    .i_txd4(txd4), .i_tx_ctl(tx_ctl), .o_rxc(rxc), .o_rx_ctl(rx_ctl),
    .o_rxd4(rxd4)
  );

  // ==========================================================
  // Monitor and hang guard
  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1)
      rx_q.push_back({rx_err, rx_last, rx_data});
    if (underrun === 1)
      underruns++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] pat(input int i);
    return 8'(85 + 29 * i);
  endfunction

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until ready is seen high at the taking edge
  task automatic push(input logic [7:0] d, input logic l, input logic e);
    logic r;
    tx_data = d;
    tx_last = l;
    tx_err = e;
    tx_valid = 1;
    do begin
      @(negedge clk);
      r = tx_ready;
      if (r !== 1)
        refused++;
      @(posedge clk);
      #1;
    end while (r !== 1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_tx(input logic md, input ep_speed_t sp, input int nb,
                      input logic lst);
    if (md != mode_ddr) begin
      // Leave reduced mode on a high clock-out phase so it toggles once more
      @(negedge clk iff ref_out === 1'b1);
      @(posedge clk);
      #1;
    end
    if (mode_ddr && speed == EP_SPD_10 && sp != speed) begin
      // Let the running slow half period finish before the rate moves
      @(txc);
      repeat (4) @(posedge clk);
      #1;
    end
    mode_ddr = md;
    speed = sp;
    refused = 0;
    underruns = 0;
    i_ep_phy_model.tx_q = {};
    repeat (20) @(posedge clk);
    #1;
    for (int i = 0; i < nb; i++)
      push(pat(i), lst && i == nb - 1, md && i == 1);
    tx_valid = 0;
    for (int k = 0; k < 4000 && i_ep_phy_model.tx_q.size() < nb; k++)
      @(posedge clk);
    repeat (60) @(posedge clk);
    #1;
    cmp(10'(i_ep_phy_model.tx_q.size()), 10'(nb));
    for (int i = 0; i < nb && i < i_ep_phy_model.tx_q.size(); i++)
      cmp({1'b0, i_ep_phy_model.tx_q[i]}, {2'h0, pat(i)} | 10'(md && i == 1) << 8);
    cmp(10'(underruns), 10'(!lst));
    cmp(10'(refused > 0), 10'(nb > 8));
    cmp({tx_ready, tx_en, tx_ctl}, 10'h4);
    $display("tx test mode %0d speed %0d done", md, sp);
  endtask

  task automatic t_rx(input logic md);
    logic [7:0] b[3];
    mode_ddr = md;
    for (int e = 0; e < 2; e++) begin
      rx_q = {};
      for (int i = 0; i < 3; i++)
        b[i] = pat(i + 4 * e);
      if (md)
        i_ep_phy_model.ddr_rx(b, e ? 1 : -1);
      else
        i_ep_phy_model.rmii_rx(b, e ? 1 : -1);
      for (int k = 0; k < 80 && rx_q.size() < 3; k++)
        @(posedge clk);
      repeat (20) @(posedge clk);
      #1;
      cmp(10'(rx_q.size()), 10'h3);
      for (int i = 0; i < 3 && i < rx_q.size(); i++)
        cmp(rx_q[i] & (i == 2 ? 10'h3ff : 10'h1ff), {e == 1 && i == 2, i == 2, b[i]});
    end
    $display("rx test mode %0d done", md);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    t_tx(0, EP_SPD_10, 12, 1);
    t_tx(0, EP_SPD_10, 3, 0);
    t_rx(0);
    t_tx(1, EP_SPD_10, 3, 1);
    t_tx(1, EP_SPD_100, 3, 1);
    t_tx(1, EP_SPD_1000, 20, 1);
    t_rx(1);
    complete_run();
  end
endmodule

`default_nettype wire
